// File: upsc_pkg.sv
/*
 * Shared constants for the UART power-save and wake control block.
 * Assumes a 125 MHz module clock and a plain strobe register port.
 */
package upsc_pkg;
    localparam int UPSC_WAKE_TIME_NS = 20000000;
    localparam int UPSC_CLK_PERIOD_NS = 8;
    localparam int UPSC_WAKE_CYCLES = (UPSC_WAKE_TIME_NS + UPSC_CLK_PERIOD_NS - 1)
        / UPSC_CLK_PERIOD_NS;
    localparam int UPSC_WCNT_W = 22;
    localparam int UPSC_PCNT_W = 16;
    localparam int UPSC_PERIOD_CYCLES = 4096;
    localparam int UPSC_ON_CYCLES = 256;
    localparam int UPSC_ACTIVE_CYCLES = 1024;
    localparam int UPSC_FIFO_DEPTH = 8;
    localparam int UPSC_DATA_W = 8;
    localparam int UPSC_PRODUCT_VERSION = 2;

    localparam logic [3:0] UPSC_ADDR_CTRL = 4'h0;
    localparam logic [3:0] UPSC_ADDR_STATUS = 4'h4;
    localparam logic [3:0] UPSC_ADDR_RXDATA = 4'h8;

    localparam int UPSC_CTRL_MODE_LSB = 0;
    localparam int UPSC_CTRL_FLOW_BIT = 2;
    localparam logic [1:0] UPSC_MODE_RESET = 2'h0;
    localparam logic UPSC_FLOW_RESET = 1'b1;

    localparam logic [1:0] UPSC_MODE_OFF = 2'h0;
    localparam logic [1:0] UPSC_MODE_PERIODIC = 2'h1;
    localparam logic [1:0] UPSC_MODE_RTS = 2'h2;
    localparam logic [1:0] UPSC_MODE_DTR = 2'h3;

    typedef enum logic [1:0] {
        UPSC_ST_IDLE = 2'b00,
        UPSC_ST_WAKE = 2'b01,
        UPSC_ST_ACTIVE = 2'b10
    } upsc_state_t;
endpackage

// File: upsc_fifo_if.sv
/*
 * Carrier between the control block and its receive FIFO.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface upsc_fifo_if #(parameter int W = 8, parameter int D = 8);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    logic [$clog2(D+1)-1:0] count;
    modport fifo (input in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data, count);
    modport user (output in_valid, in_data, out_ready,
                  input in_ready, out_valid, out_data, count);
endinterface
`default_nettype wire

// File: upsc_fifo.sv
/*
 * Receive FIFO with valid and ready on both sides.
 * Assumes one clock, a clock enable that freezes it, and asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
module upsc_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    upsc_fifo_if.fifo f
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D+1);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } upsc_fifo_st_t;
    upsc_fifo_st_t r_reg;
    upsc_fifo_st_t r_next;
    logic push;
    logic pop;

    assign f.in_ready = (r_reg.cnt != CW'(D));
    assign f.out_valid = (r_reg.cnt != '0);
    assign f.out_data = r_reg.mem[r_reg.rp];
    assign f.count = r_reg.cnt;
    assign push = f.in_valid && f.in_ready;
    assign pop = f.out_ready && f.out_valid;

    always_comb begin
        r_next = r_reg;
        if (push) begin
            r_next.mem[r_reg.wp] = f.in_data;
            r_next.wp = (r_reg.wp == AW'(D-1)) ? '0 : r_reg.wp + 1'b1;
        end
        if (pop) begin
            r_next.rp = (r_reg.rp == AW'(D-1)) ? '0 : r_reg.rp + 1'b1;
        end
        r_next.cnt = r_reg.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end
endmodule
`default_nettype wire

// File: upsc_top.sv
/*
 * UART power-save and wake control, device side, with receive FIFO.
 * Assumes RTS and DTR arrive from pins (active low, ON = low) and that the
 * receiver hands characters over on this clock with valid and ready.
 */
`timescale 1ns/100ps
`default_nettype none
module upsc_top
    import upsc_pkg::*;
#(
    parameter int WAKE_CYCLES = UPSC_WAKE_CYCLES,
    parameter int PERIOD_CYCLES = UPSC_PERIOD_CYCLES,
    parameter int ON_CYCLES = UPSC_ON_CYCLES,
    parameter int ACTIVE_CYCLES = UPSC_ACTIVE_CYCLES,
    parameter int PRODUCT_VERSION = UPSC_PRODUCT_VERSION,
    parameter int FIFO_DEPTH = UPSC_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic rts_n,
    input wire logic dtr_n,
    output logic cts_n,
    input wire logic tx_pending,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic uart_en,
    output logic idle
);
    localparam int CW = $clog2(FIFO_DEPTH+1);

    typedef struct packed {
        logic [1:0] mode;
        logic flow;
        upsc_state_t st;
        logic [UPSC_WCNT_W-1:0] wake_cnt;
        logic [UPSC_PCNT_W-1:0] per_cnt;
        logic [UPSC_PCNT_W-1:0] act_cnt;
        logic uart_en;
        logic cts_n;
        logic rx_ready;
        logic idle;
        logic [31:0] rdata;
        logic rts_s1;
        logic rts_s2;
        logic dtr_s1;
        logic dtr_s2;
    } upsc_st_t;

    upsc_st_t r_reg;
    upsc_st_t r_next;
    logic line_on;
    logic line_mode;
    logic push;
    logic pop;
    logic [CW-1:0] cnt_next;
    logic [1:0] new_mode;
    logic new_flow;

    upsc_fifo_if #(.W(UPSC_DATA_W), .D(FIFO_DEPTH)) fi ();

    upsc_fifo #(.W(UPSC_DATA_W), .D(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .f(fi.fifo)
    );

    ////////////////////////////////////////////////////////////////////////////////

    // Characters that arrive while the UART is off are taken and thrown away.
    assign push = rx_valid && r_reg.rx_ready && r_reg.uart_en;
    assign pop = rd && (addr == UPSC_ADDR_RXDATA) && fi.out_valid;
    assign fi.in_valid = push;
    assign fi.in_data = rx_data;
    assign fi.out_ready = pop;
    assign cnt_next = fi.count + CW'(push) - CW'(pop);
    assign line_mode = r_reg.mode[1];
    assign line_on = (r_reg.mode == UPSC_MODE_RTS) ? !r_reg.rts_s2 : !r_reg.dtr_s2;
    assign new_mode = wdata[UPSC_CTRL_MODE_LSB +: 2];
    assign new_flow = wdata[UPSC_CTRL_FLOW_BIT];

    always_comb begin
        r_next = r_reg;
        r_next.rts_s1 = rts_n;
        r_next.rts_s2 = r_reg.rts_s1;
        r_next.dtr_s1 = dtr_n;
        r_next.dtr_s2 = r_reg.dtr_s1;

        // Power-save and flow-control commands.
        if (wr && addr == UPSC_ADDR_CTRL) begin
            r_next.flow = new_flow;
            // An RTS setting is refused when the same write turns flow control on; flow can still be turned on while RTS stays set.
            if (new_mode == UPSC_MODE_DTR && PRODUCT_VERSION == 1) begin
                r_next.mode = r_reg.mode;
            end else if (new_mode == UPSC_MODE_RTS && new_flow) begin
                r_next.mode = r_reg.mode;
            end else begin
                r_next.mode = new_mode;
            end
        end

        unique case (r_reg.st)
            UPSC_ST_IDLE: begin
                r_next.per_cnt = r_reg.per_cnt + 1'b1;
                if (tx_pending || r_reg.mode == UPSC_MODE_OFF) begin
                    r_next.st = UPSC_ST_ACTIVE;
                    r_next.act_cnt = UPSC_PCNT_W'(ACTIVE_CYCLES);
                end else if (line_mode) begin
                    // The wake timer only starts once the line has been seen ON.
                    if (line_on) begin
                        r_next.st = UPSC_ST_WAKE;
                        r_next.wake_cnt = UPSC_WCNT_W'(WAKE_CYCLES - 1);
                    end
                end else if (r_reg.per_cnt >= UPSC_PCNT_W'(PERIOD_CYCLES - 1)) begin
                    r_next.st = UPSC_ST_ACTIVE;
                    r_next.per_cnt = '0;
                    r_next.act_cnt = UPSC_PCNT_W'(ON_CYCLES);
                end
            end
            UPSC_ST_WAKE: begin
                if (!line_mode || !line_on) begin
                    r_next.st = UPSC_ST_IDLE;
                end else if (r_reg.wake_cnt == '0) begin
                    r_next.st = UPSC_ST_ACTIVE;
                end else begin
                    r_next.wake_cnt = r_reg.wake_cnt - 1'b1;
                end
            end
            UPSC_ST_ACTIVE: begin
                if (line_mode) begin
                    if (!line_on && !tx_pending) begin
                        r_next.st = UPSC_ST_IDLE;
                    end
                end else if (r_reg.mode == UPSC_MODE_PERIODIC) begin
                    // Each received character restarts the active window.
                    if (push || tx_pending) begin
                        r_next.act_cnt = UPSC_PCNT_W'(ACTIVE_CYCLES);
                    end else if (r_reg.act_cnt == '0) begin
                        r_next.st = UPSC_ST_IDLE;
                        r_next.per_cnt = '0;
                    end else begin
                        r_next.act_cnt = r_reg.act_cnt - 1'b1;
                    end
                end
            end
            default: begin
                r_next.st = UPSC_ST_IDLE;
            end
        endcase

        // A fresh periodic command with tx_pending low skips the timeout and drops the UART at once.
        if (wr && addr == UPSC_ADDR_CTRL && r_next.mode == UPSC_MODE_PERIODIC
            && r_reg.mode != UPSC_MODE_PERIODIC && !tx_pending) begin
            r_next.st = UPSC_ST_IDLE;
            r_next.per_cnt = '0;
        end

        r_next.uart_en = (r_next.st == UPSC_ST_ACTIVE);
        r_next.cts_n = r_next.flow ? !r_next.uart_en : 1'b0;
        r_next.rx_ready = !r_next.uart_en || (cnt_next != CW'(FIFO_DEPTH));
        r_next.idle = (r_next.st == UPSC_ST_IDLE) && !r_next.uart_en;

        r_next.rdata = 32'h0;
        if (rd) begin
            unique case (addr)
                UPSC_ADDR_CTRL: begin
                    r_next.rdata = {29'h0, r_reg.flow, r_reg.mode};
                end
                UPSC_ADDR_STATUS: begin
                    r_next.rdata = {24'h0, 4'(fi.count), r_reg.st,
                                    (r_reg.st == UPSC_ST_IDLE), r_reg.uart_en};
                end
                UPSC_ADDR_RXDATA: begin
                    r_next.rdata = {23'h0, fi.out_valid, fi.out_data};
                end
                default: begin
                    r_next.rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
            r_reg.mode <= UPSC_MODE_RESET;
            r_reg.flow <= UPSC_FLOW_RESET;
            r_reg.st <= UPSC_ST_IDLE;
            r_reg.cts_n <= 1'b1;
            r_reg.rx_ready <= 1'b1;
            r_reg.idle <= 1'b1;
            r_reg.rts_s1 <= 1'b1;
            r_reg.rts_s2 <= 1'b1;
            r_reg.dtr_s1 <= 1'b1;
            r_reg.dtr_s2 <= 1'b1;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign rdata = r_reg.rdata;
    assign cts_n = r_reg.cts_n;
    assign rx_ready = r_reg.rx_ready;
    assign uart_en = r_reg.uart_en;
    assign idle = r_reg.idle;

    ////////////////////////////////////////////////////////////////////////////////

    property p_cts_follows_uart;
        @(posedge clk) disable iff (!arst_n)
        r_reg.flow |-> (r_reg.cts_n == !r_reg.uart_en);
    endproperty
    a_cts_follows_uart: assert property (p_cts_follows_uart)
        else $error("CTS does not follow UART enable.");

    property p_line_off_drops;
        @(posedge clk) disable iff (!arst_n)
        ce && line_mode && !line_on && !tx_pending && !wr |=> !r_reg.uart_en;
    endproperty
    a_line_off_drops: assert property (p_line_off_drops)
        else $error("UART still enabled after line OFF.");

    property p_wake_not_early;
        @(posedge clk) disable iff (!arst_n)
        r_reg.st == UPSC_ST_WAKE |-> !r_reg.uart_en;
    endproperty
    a_wake_not_early: assert property (p_wake_not_early)
        else $error("UART enabled during wake delay.");

    property p_wake_done;
        @(posedge clk) disable iff (!arst_n)
        ce && r_reg.st == UPSC_ST_WAKE && r_reg.wake_cnt == '0 && line_on && line_mode && !wr
        |=> r_reg.uart_en;
    endproperty
    a_wake_done: assert property (p_wake_done)
        else $error("UART not enabled when wake delay ended.");

    property p_wake_start;
        @(posedge clk) disable iff (!arst_n)
        ce && r_reg.st == UPSC_ST_IDLE && line_mode && line_on && !tx_pending && !wr
        |=> r_reg.st == UPSC_ST_WAKE && r_reg.wake_cnt == UPSC_WCNT_W'(WAKE_CYCLES - 1);
    endproperty
    a_wake_start: assert property (p_wake_start)
        else $error("Wake timer not loaded on line ON.");

    property p_line_on_stays;
        @(posedge clk) disable iff (!arst_n)
        ce && r_reg.uart_en && line_mode && line_on && !wr |=> r_reg.uart_en;
    endproperty
    a_line_on_stays: assert property (p_line_on_stays)
        else $error("UART dropped while line ON.");

    property p_no_dtr_v01;
        @(posedge clk) disable iff (!arst_n)
        PRODUCT_VERSION == 1 |-> r_reg.mode != UPSC_MODE_DTR;
    endproperty
    a_no_dtr_v01: assert property (p_no_dtr_v01)
        else $error("DTR setting active on version 01.");

    property p_flow_write;
        @(posedge clk) disable iff (!arst_n)
        ce && wr && addr == UPSC_ADDR_CTRL |=> r_reg.flow == $past(wdata[UPSC_CTRL_FLOW_BIT]);
    endproperty
    a_flow_write: assert property (p_flow_write)
        else $error("Flow control bit not updated.");

    property p_drop_when_off;
        @(posedge clk) disable iff (!arst_n)
        ce && !r_reg.uart_en && !pop |=> $stable(fi.count);
    endproperty
    a_drop_when_off: assert property (p_drop_when_off)
        else $error("Data stored while UART disabled.");

    property p_periodic_window;
        @(posedge clk) disable iff (!arst_n)
        ce && r_reg.mode == UPSC_MODE_PERIODIC && r_reg.st == UPSC_ST_ACTIVE
        && r_reg.act_cnt == '0 && !push && !tx_pending && !wr |=> !r_reg.uart_en;
    endproperty
    a_periodic_window: assert property (p_periodic_window)
        else $error("Periodic window did not close.");

    property p_cts_low_flow_off;
        @(posedge clk) disable iff (!arst_n)
        !r_reg.flow |-> !r_reg.cts_n;
    endproperty
    a_cts_low_flow_off: assert property (p_cts_low_flow_off)
        else $error("CTS not low with flow control off.");

    property p_rts_needs_flow_off;
        @(posedge clk) disable iff (!arst_n)
        ce && wr && addr == UPSC_ADDR_CTRL && new_mode == UPSC_MODE_RTS && new_flow
        |=> r_reg.mode == $past(r_reg.mode);
    endproperty
    a_rts_needs_flow_off: assert property (p_rts_needs_flow_off)
        else $error("RTS setting taken with flow control on.");

    property p_dtr_refused_v01;
        @(posedge clk) disable iff (!arst_n)
        ce && wr && addr == UPSC_ADDR_CTRL && new_mode == UPSC_MODE_DTR && PRODUCT_VERSION == 1
        |=> r_reg.mode == $past(r_reg.mode);
    endproperty
    a_dtr_refused_v01: assert property (p_dtr_refused_v01)
        else $error("DTR setting taken on version 01.");

    property p_wake_counts;
        @(posedge clk) disable iff (!arst_n)
        ce && r_reg.st == UPSC_ST_WAKE && r_reg.wake_cnt != '0 && line_mode && line_on && !wr
        |=> r_reg.st == UPSC_ST_WAKE && r_reg.wake_cnt == $past(r_reg.wake_cnt) - 1'b1;
    endproperty
    a_wake_counts: assert property (p_wake_counts)
        else $error("Wake timer did not count down.");

    property p_period_shut;
        @(posedge clk) disable iff (!arst_n)
        ce && r_reg.mode == UPSC_MODE_PERIODIC && r_reg.st == UPSC_ST_IDLE && !tx_pending && !wr
        && r_reg.per_cnt < UPSC_PCNT_W'(PERIOD_CYCLES - 1) |=> !r_reg.uart_en;
    endproperty
    a_period_shut: assert property (p_period_shut)
        else $error("UART opened before the period ended.");

    property p_rx_stored;
        @(posedge clk) disable iff (!arst_n)
        ce && push && !pop |=> fi.count == $past(fi.count) + CW'(1);
    endproperty
    a_rx_stored: assert property (p_rx_stored)
        else $error("Accepted character not stored.");

    property p_rx_popped;
        @(posedge clk) disable iff (!arst_n)
        ce && pop && !push |=> fi.count == $past(fi.count) - CW'(1);
    endproperty
    a_rx_popped: assert property (p_rx_popped)
        else $error("Read character not removed.");

    c_wake_to_active: cover property (@(posedge clk) disable iff (!arst_n)
        r_reg.st == UPSC_ST_WAKE ##1 r_reg.st == UPSC_ST_ACTIVE);
    c_wake_abort: cover property (@(posedge clk) disable iff (!arst_n)
        r_reg.st == UPSC_ST_WAKE ##1 r_reg.st == UPSC_ST_IDLE);
    c_periodic_open: cover property (@(posedge clk) disable iff (!arst_n)
        r_reg.mode == UPSC_MODE_PERIODIC && $rose(r_reg.uart_en));
    c_fifo_full: cover property (@(posedge clk) disable iff (!arst_n)
        fi.count == CW'(FIFO_DEPTH));
    c_rx_in_periodic: cover property (@(posedge clk) disable iff (!arst_n)
        r_reg.mode == UPSC_MODE_PERIODIC && push);
endmodule
`default_nettype wire

// File: upsc_dte_model.sv
/*
 * Behavioural model of the application processor acting as serial DTE.
 * Assumes the bench loads bytes through push and states whether flow control is on.
 */
`timescale 1ns/100ps
`default_nettype none
module upsc_dte_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic flow,
    input wire logic cts_n,
    input wire logic rx_ready,
    input wire logic push,
    input wire logic [7:0] push_data,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    ////////////////////////////////////////////////////////////////////////////////
    // This DTE needs no DSR, DCD or RI input at all.
    logic [7:0] q[$];

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q.delete();
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            if (rx_valid && rx_ready) begin
                void'(q.pop_front());
            end
            if (push) begin
                q.push_back(push_data);
            end
            // Pending bytes stay in the own buffer while CTS is OFF and flow control is on.
            if (q.size() > 0 && (!flow || !cts_n)) begin
                rx_valid <= 1'b1;
                rx_data <= q[0];
            end else begin
                // Idle data toggles so that a stale byte can never pass for a fresh one.
                rx_valid <= 1'b0;
                rx_data <= ~rx_data;
            end
        end
    end
endmodule
`default_nettype wire

// File: upsc_bench.sv
/*
 * Self-checking bench for the UART power-save and wake control block.
 * Assumes shortened wake, period and active counts and a 125 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
module upsc_bench
    import upsc_pkg::*;
;
    localparam int W = 20;
    localparam int P = 64;
    localparam int O = 8;
    localparam int A = 16;
    logic clk, arst_n, ce, wr, rd, rts_n, dtr_n, tx_pending, flow, push;
    logic cts_n, rx_valid, rx_ready, uart_en, idle;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, rv, rdata_v1;
    logic [7:0] push_data, rx_data;
    int n_mismatch, n_compared, n, k;

    upsc_top #(.WAKE_CYCLES(W), .PERIOD_CYCLES(P), .ON_CYCLES(O), .ACTIVE_CYCLES(A)) dut (
        .clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .rts_n(rts_n), .dtr_n(dtr_n), .cts_n(cts_n),
        .tx_pending(tx_pending), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .uart_en(uart_en), .idle(idle));
    upsc_dte_model dte (.clk(clk), .arst_n(arst_n), .flow(flow), .cts_n(cts_n),
        .rx_ready(rx_ready), .push(push), .push_data(push_data), .rx_valid(rx_valid),
        .rx_data(rx_data));
    // A second copy built as version 01 shows that the DTR setting is refused there.
    upsc_top #(.WAKE_CYCLES(W), .PERIOD_CYCLES(P), .ON_CYCLES(O), .ACTIVE_CYCLES(A),
        .PRODUCT_VERSION(1)) dut_v1 (
        .clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata_v1), .rts_n(rts_n), .dtr_n(dtr_n), .cts_n(),
        .tx_pending(tx_pending), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(), .uart_en(), .idle());

    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Counts edges until uart_en reaches v; the caller bounds the count.
    task expect_en(input logic v, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while (uart_en !== v && cnt < lim);
        check({31'h0, uart_en}, {31'h0, v});
    endtask
    task load(input int cnt, input logic [7:0] base);
        for (int i = 0; i < cnt; i++) begin
            @(posedge clk);
            push <= 1'b1;
            push_data <= base + i[7:0];
        end
        @(posedge clk);
        push <= 1'b0;
    endtask
    task pop_chk(input int cnt, input logic [7:0] base);
        for (int i = 0; i < cnt; i++) begin
            rd_reg(UPSC_ADDR_RXDATA, rv);
            check(rv, {23'h0, 1'b1, base + i[7:0]});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        rd_reg(UPSC_ADDR_CTRL, rv);
        check(rv, 32'h4);
        check({30'h0, uart_en, cts_n}, 32'h2);
        rd_reg(4'hc, rv);
        check(rv, 32'h0);
        wr_reg(UPSC_ADDR_CTRL, 32'h6);
        rd_reg(UPSC_ADDR_CTRL, rv);
        check(rv, 32'h4);
        $display("test reset finished");
    endtask
    task t_fifo;
        load(10, 8'h30);
        repeat (4) @(posedge clk);
        #1;
        check({31'h0, rx_ready}, 32'h0);
        rd_reg(UPSC_ADDR_STATUS, rv);
        check({28'h0, rv[7:4]}, 32'h8);
        pop_chk(10, 8'h30);
        rd_reg(UPSC_ADDR_RXDATA, rv);
        check({31'h0, rv[8]}, 32'h0);
        $display("test fifo finished");
    endtask
    task t_rts;
        flow <= 1'b0;
        dtr_n <= 1'b0;
        wr_reg(UPSC_ADDR_CTRL, 32'h2);
        expect_en(1'b0, 8, n);
        check({31'h0, cts_n}, 32'h0);
        @(posedge clk);
        tx_pending <= 1'b1;
        expect_en(1'b1, 4, n);
        tx_pending <= 1'b0;
        expect_en(1'b0, A + 8, n);
        repeat (4) @(posedge clk);
        rts_n <= 1'b0;
        expect_en(1'b1, W + 8, n);
        check({31'h0, n >= W + 2 && n <= W + 5}, 32'h1);
        k = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (uart_en !== 1'b1) k++;
        end
        check(k, 32'h0);
        @(posedge clk);
        rts_n <= 1'b1;
        expect_en(1'b0, 4, n);
        $display("test rts finished");
    endtask
    task t_dtr;
        flow <= 1'b1;
        dtr_n <= 1'b1;
        wr_reg(UPSC_ADDR_CTRL, 32'h7);
        rd_reg(UPSC_ADDR_CTRL, rv);
        check(rv, 32'h7);
        check(rdata_v1, 32'h6);
        expect_en(1'b0, 8, n);
        check({31'h0, cts_n}, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        check({31'h0, idle}, 32'h1);
        @(posedge clk);
        dtr_n <= 1'b0;
        expect_en(1'b1, W + 8, n);
        check({31'h0, n >= W + 2 && n <= W + 5}, 32'h1);
        check({31'h0, cts_n}, 32'h0);
        load(2, 8'h50);
        repeat (4) @(posedge clk);
        pop_chk(2, 8'h50);
        @(posedge clk);
        dtr_n <= 1'b1;
        expect_en(1'b0, 4, n);
        check({31'h0, cts_n}, 32'h1);
        $display("test dtr finished");
    endtask
    task t_periodic;
        // Bytes are loaded while the port is shut, so they must wait for the window.
        wr_reg(UPSC_ADDR_CTRL, 32'h5);
        load(3, 8'h70);
        expect_en(1'b1, P + 8, n);
        check({31'h0, n + 4 >= P - 3 && n + 4 <= P + 4}, 32'h1);
        expect_en(1'b0, A + O + 8, n);
        rd_reg(UPSC_ADDR_STATUS, rv);
        check({28'h0, rv[7:4]}, 32'h3);
        pop_chk(3, 8'h70);
        $display("test periodic finished");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out;
    end
    initial begin
        {arst_n, wr, rd, tx_pending, push} = 5'h00;
        {ce, rts_n, dtr_n, flow} = 4'hf;
        addr = 4'h0;
        wdata = 32'h0;
        push_data = 8'h00;
        n_mismatch = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        t_reset;
        t_fifo;
        t_rts;
        t_dtr;
        t_periodic;
        close_out;
    end
endmodule
`default_nettype wire
